// *** repeater_strap_config_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module repeater_strap_config_control_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cab = 1'b0, st_n = 1'b1, fail = 1'b0, rw = 1'b0, rr = 1'b0;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0, rdata, eq, de, ewd;
  logic [1:0] lv [12] = '{default: 2'h0};
  logic [1:0] rate;
  logic [3:0] sa;
  logic a2b, b2a, t50, lp, en, dn, irq, req, ewr, edn, eer, sda, scl;
  logic drv = 1'b1, sdo, soe, sco, coe, mben;
  int errors = 0, num_checks = 0;

  // pad comparator view of a strap level code
  function automatic logic [2:0] t(input logic [1:0] l);
    t = {l == 2'h3, l[1], l != 2'h0};
  endfunction

  initial forever #12.5 clk = ~clk;

  rsc_strap_cfg dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .MODE_SEL_TH_I(t(lv[0])),
    .BANK_A_EQ_SEL0_TH_I(t(lv[1])), .BANK_A_EQ_SEL1_TH_I(t(lv[2])),
    .BANK_B_EQ_SEL0_TH_I(t(lv[3])), .BANK_B_EQ_SEL1_TH_I(t(lv[4])),
    .BANK_A_DEEMPH_SEL0_TH_I(t(lv[5])), .BANK_A_DEEMPH_SEL1_TH_I(t(lv[6])),
    .BANK_B_DEEMPH_SEL0_TH_I(t(lv[7])), .BANK_B_DEEMPH_SEL1_TH_I(t(lv[8])),
    .RATE_SEL_TH_I(t(lv[9])), .RX_DETECT_SEL_TH_I(t(lv[10])), .LOOPBACK_SEL_TH_I(t(lv[11])),
    .CABLE_ABSENT_I(cab), .EE_LOAD_START_N_I(st_n), .MB_SDA_DRV_LOW_I(drv),
    .MB_SCL_DRV_LOW_I(drv), .MGMT_SDA_O(sdo), .MGMT_SDA_OE_O(soe), .MGMT_SCL_O(sco),
    .MGMT_SCL_OE_O(coe), .MB_EN_O(mben), .MB_SDA_O(sda), .MB_SCL_O(scl), .SLAVE_ADDR_PINS_O(sa),
    .REG_ADDR_I(ra), .REG_WDATA_I(wd), .REG_WR_I(rw), .REG_RD_I(rr), .REG_RDATA_O(rdata),
    .EE_LOAD_REQ_O(req), .EE_WR_I(ewr), .EE_ADDR_I(8'h00), .EE_WDATA_I(ewd),
    .EE_DONE_I(edn), .EE_ERR_I(eer), .CH_EQ_O(eq), .CH_DEEMPH_O(de), .RATE_MODE_O(rate),
    .LOOP_A2B_O(a2b), .LOOP_B2A_O(b2a), .TERM_50_O(t50), .LOW_POWER_O(lp), .CH_EN_O(en),
    .LOAD_DONE_N_O(dn), .IRQ_O(irq));

  rsc_ee_model ee (.clk_i(clk), .rstn_i(rstn), .req_i(req), .fail_i(fail), .wr_o(ewr),
    .wdata_o(ewd), .done_o(edn), .err_o(eer));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    rw <= 1'b1;
    ra <= a;
    wd <= d;
    wt(1);
    rw <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so take it mid-cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    rr <= 1'b1;
    ra <= a;
    wt(1);
    rr <= 1'b0;
    @(negedge clk);
    d = rdata;
    wt(1);
  endtask

  // straps settle through sync and filter, so allow a generous fixed span
  task automatic rst;
    rstn <= 1'b0;
    wt(3);
    rstn <= 1'b1;
    wt(15);
  endtask

  task automatic t_strap;
    lv[1] <= 2'h1;
    lv[2] <= 2'h2;
    lv[3] <= 2'h3;
    lv[5] <= 2'h2;
    lv[6] <= 2'h3;
    lv[8] <= 2'h1;
    wt(15);
    chk("eq", eq, 32'h3333_9999);
    chk("deemph", de, 32'h4444_EEEE);
    chk("done_n", dn, 1'b1);
    chk("bus pins", {soe, coe, mben, sdo, sco}, 5'h0);
    $display("strap banks done");
  endtask

  task automatic t_modes;
    logic [1:0] rt [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
    for (int k = 0; k < 4; k++) begin
      lv[9] <= 2'(k);
      lv[10] <= 2'(k);
      lv[11] <= 2'(k);
      cab <= k[0];
      wt(15);
      chk("rate", rate, rt[k]);
      chk("loop", {b2a, a2b}, {k == 3, k == 0});
      chk("term", t50, k != 0);
      chk("power", {lp, en}, {k[0], !k[0]});
    end
    $display("mode straps done");
  endtask

  task automatic t_reg;
    logic [31:0] d;
    lv[0] <= 2'h3;
    lv[4] <= 2'h0;
    lv[8] <= 2'h2;
    lv[6] <= 2'h0;
    wt(15);
    chk("addr", sa, 4'h9);
    chk("bus", {sda, scl}, 2'h2);
    chk("drive", {soe, coe, mben}, 3'h7);
    drv <= 1'b0;
    wr(8'h00, 32'hA5A5_5A5A);
    lv[1] <= 2'h3;
    wt(15);
    chk("eq", eq, 32'hA5A5_5A5A);
    chk("release", {soe, coe}, 2'h0);
    rd(8'h08, d);
    chk("mode", d[1:0], 2'h2);
    rd(8'h40, d);
    chk("unmapped", d, 32'h0);
    chk("irq masked", irq, 1'b0);
    wr(8'h14, 32'hF);
    wt(2);
    chk("irq", irq, 1'b1);
    wr(8'h10, 32'hF);
    wt(2);
    chk("irq clear", irq, 1'b0);
    $display("register mode done");
  endtask

  // a failed load must leave the status pin high and the host locked out
  task automatic t_ee(input logic f);
    logic [31:0] d;
    lv[0] <= 2'h2;
    fail <= f;
    rst;
    chk("done_n", dn, 1'b1);
    st_n <= 1'b0;
    repeat (40) if (dn === 1'b1) wt(1);
    chk("done_n", dn, f);
    rd(8'h08, d);
    chk("locked", d == 32'h0, f);
    chk("passed", d[7], !f);
    chk("bus en", mben, !f);
    if (!f) chk("eq", eq, 32'h7654_3210);
    st_n <= 1'b1;
    $display("eeprom load done");
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    rst;
    t_strap;
    t_modes;
    t_reg;
    t_ee(1'b0);
    t_ee(1'b1);
    conclude;
  end

  // whole run needs well under a thousand cycles
  initial begin
    #(25 * 4000);
    errors++;
    conclude;
  end
endmodule

`default_nettype wire

// *** rsc_ee_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// config memory side: answers a load request with one word, then done or error
module rsc_ee_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // request and fault choice
  input wire logic req_i,
  input wire logic fail_i,
  // loader writes
  output logic wr_o,
  output logic [31:0] wdata_o,
  output logic done_o,
  output logic err_o
);
  logic [2:0] cnt;

  // paced slowly so the busy window is seen from the host side
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 3'h0;
    end else begin
      cnt <= req_i ? cnt + 3'h1 : 3'h0;
    end
  end

  // one word at offset zero, then a single finishing pulse
  assign wr_o = req_i && cnt == 3'h2;
  assign wdata_o = 32'h7654_3210;
  assign done_o = req_i && cnt == 3'h5 && !fail_i;
  assign err_o = req_i && cnt == 3'h5 && fail_i;
endmodule

`default_nettype wire

// *** rsc_lvl4.sv ***
`timescale 1ns/100ps
`default_nettype none

// four-level strap: sync, thermometer decode, settle filter
module rsc_lvl4 (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // pad comparators, bit n high when above threshold n
  input wire logic [2:0] th_i,
  // decoded level and two-level reading
  output logic [1:0] lvl_o,
  output logic dig_o
);

  localparam logic [2:0] SETTLE_M1 = 3'(rsc_pkg::STRAP_SETTLE_CYC - 1);

  logic [2:0] meta;
  logic [2:0] th_s;
  logic [1:0] cand;
  logic [1:0] last;
  logic valid;
  logic [2:0] cnt;

  // two flops before any decode
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= 3'h0;
      th_s <= 3'h0;
    end else begin
      meta <= th_i;
      th_s <= meta;
    end
  end

  // non-thermometer patterns are edges in flight, never a level
  always_comb begin
    valid = 1'b1;
    case (th_s)
      3'h0: cand = rsc_pkg::LVL_GND1K;
      3'h1: cand = rsc_pkg::LVL_GND20K;
      3'h3: cand = rsc_pkg::LVL_FLOAT;
      3'h7: cand = rsc_pkg::LVL_VDD1K;
      default: begin
        cand = rsc_pkg::LVL_GND1K;
        valid = 1'b0;
      end
    endcase
  end

  // level taken only after it held for the settle time
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last <= rsc_pkg::LVL_GND1K;
      cnt <= 3'h0;
      lvl_o <= rsc_pkg::LVL_GND1K;
    end else if (!valid || cand != last) begin
      last <= cand;
      cnt <= 3'h0;
    end else if (cnt != SETTLE_M1) begin
      cnt <= cnt + 3'h1;
    end else begin
      lvl_o <= last;
    end
  end

  // mid threshold serves as logic level when the pin is reused
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dig_o <= 1'b1;
    end else begin
      dig_o <= th_s[1];
    end
  end

endmodule

`default_nettype wire

// *** rsc_pkg.sv ***
package rsc_pkg;

  // ----------------------------------------------------------------
  // four-level strap codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LVL_GND1K = 2'h0;
  localparam logic [1:0] LVL_GND20K = 2'h1;
  localparam logic [1:0] LVL_FLOAT = 2'h2;
  localparam logic [1:0] LVL_VDD1K = 2'h3;

  // ----------------------------------------------------------------
  // rate mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_GEN12 = 2'h0;
  localparam logic [1:0] RATE_AUTO = 2'h1;
  localparam logic [1:0] RATE_GEN3 = 2'h2;
  localparam logic [1:0] RATE_RSVD = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int STRAP_SETTLE_NS = 100;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // sizes, register map and fields
  // ----------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int SET_W = 4;
  localparam int IRQ_W = 4;
  localparam logic [7:0] REG_EQ_OFS = 8'h00;
  localparam logic [7:0] REG_DE_OFS = 8'h04;
  localparam logic [7:0] REG_STAT_OFS = 8'h08;
  localparam logic [7:0] REG_IRQ_ST_OFS = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR_OFS = 8'h10;
  localparam logic [7:0] REG_IRQ_EN_OFS = 8'h14;
  localparam logic [31:0] EQ_RST = 32'h0000_0000;
  localparam logic [31:0] DE_RST = 32'h0000_0000;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_RATE_LSB = 2;
  localparam int STAT_A2B = 4;
  localparam int STAT_B2A = 5;
  localparam int STAT_CABLE = 6;
  localparam int STAT_PASS = 7;
  localparam int STAT_FAIL = 8;
  localparam int IRQ_MODE = 0;
  localparam int IRQ_CABLE = 1;
  localparam int IRQ_PASS = 2;
  localparam int IRQ_FAIL = 3;

  typedef enum logic [1:0] {MODE_STRAP, MODE_EE_MASTER, MODE_REG_SLAVE} rsc_mode_e;
  typedef enum logic [2:0] {LD_IDLE, LD_WAIT, LD_BUSY, LD_PASS, LD_FAIL} rsc_load_e;

endpackage

// *** rsc_strap_cfg.sv ***
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module rsc_strap_cfg (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  // four-level strap comparators
  input wire logic [2:0] MODE_SEL_TH_I,
  input wire logic [2:0] BANK_A_EQ_SEL0_TH_I,
  input wire logic [2:0] BANK_A_EQ_SEL1_TH_I,
  input wire logic [2:0] BANK_B_EQ_SEL0_TH_I,
  input wire logic [2:0] BANK_B_EQ_SEL1_TH_I,
  input wire logic [2:0] BANK_A_DEEMPH_SEL0_TH_I,
  input wire logic [2:0] BANK_A_DEEMPH_SEL1_TH_I,
  input wire logic [2:0] BANK_B_DEEMPH_SEL0_TH_I,
  input wire logic [2:0] BANK_B_DEEMPH_SEL1_TH_I,
  input wire logic [2:0] RATE_SEL_TH_I,
  input wire logic [2:0] RX_DETECT_SEL_TH_I,
  input wire logic [2:0] LOOPBACK_SEL_TH_I,
  // two-level pins
  input wire logic CABLE_ABSENT_I,
  input wire logic EE_LOAD_START_N_I,
  // management bus pin drive (open drain on bank A de-emphasis pins)
  input wire logic MB_SDA_DRV_LOW_I,
  input wire logic MB_SCL_DRV_LOW_I,
  output logic MGMT_SDA_O,
  output logic MGMT_SDA_OE_O,
  output logic MGMT_SCL_O,
  output logic MGMT_SCL_OE_O,
  // management bus engine side
  output logic MB_EN_O,
  output logic MB_SDA_O,
  output logic MB_SCL_O,
  output logic [3:0] SLAVE_ADDR_PINS_O,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  // eeprom loader
  output logic EE_LOAD_REQ_O,
  input wire logic EE_WR_I,
  input wire logic [7:0] EE_ADDR_I,
  input wire logic [31:0] EE_WDATA_I,
  input wire logic EE_DONE_I,
  input wire logic EE_ERR_I,
  // settings to the lanes
  output logic [31:0] CH_EQ_O,
  output logic [31:0] CH_DEEMPH_O,
  output logic [1:0] RATE_MODE_O,
  output logic LOOP_A2B_O,
  output logic LOOP_B2A_O,
  output logic TERM_50_O,
  output logic LOW_POWER_O,
  output logic CH_EN_O,
  // status
  output logic LOAD_DONE_N_O,
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // strap decode
  // ----------------------------------------------------------------
  logic [1:0] mode_lvl, eqa0, eqa1, eqb0, eqb1, dea0, dea1, deb0, deb1;
  logic [1:0] rate_lvl, rx_det_lvl, loop_lvl;
  logic eqb0_dig, eqb1_dig, dea0_dig, dea1_dig, deb0_dig, deb1_dig;
  logic cable_abs_s, start_n_s;

  // each strap arrives as a settled two-bit level code
  rsc_lvl4 u_mode (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .th_i(MODE_SEL_TH_I),
    .lvl_o(mode_lvl), .dig_o());
  rsc_lvl4 u_eqa0 (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .th_i(BANK_A_EQ_SEL0_TH_I),
    .lvl_o(eqa0), .dig_o());
  rsc_lvl4 u_eqa1 (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .th_i(BANK_A_EQ_SEL1_TH_I),
    .lvl_o(eqa1), .dig_o());
  rsc_lvl4 u_eqb0 (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .th_i(BANK_B_EQ_SEL0_TH_I),
    .lvl_o(eqb0), .dig_o(eqb0_dig));
  rsc_lvl4 u_eqb1 (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .th_i(BANK_B_EQ_SEL1_TH_I),
    .lvl_o(eqb1), .dig_o(eqb1_dig));
  rsc_lvl4 u_dea0 (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .th_i(BANK_A_DEEMPH_SEL0_TH_I),
    .lvl_o(dea0), .dig_o(dea0_dig));
  rsc_lvl4 u_dea1 (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .th_i(BANK_A_DEEMPH_SEL1_TH_I),
    .lvl_o(dea1), .dig_o(dea1_dig));
  rsc_lvl4 u_deb0 (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .th_i(BANK_B_DEEMPH_SEL0_TH_I),
    .lvl_o(deb0), .dig_o(deb0_dig));
  rsc_lvl4 u_deb1 (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .th_i(BANK_B_DEEMPH_SEL1_TH_I),
    .lvl_o(deb1), .dig_o(deb1_dig));
  rsc_lvl4 u_rate (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .th_i(RATE_SEL_TH_I),
    .lvl_o(rate_lvl), .dig_o());
  rsc_lvl4 u_rx_det (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .th_i(RX_DETECT_SEL_TH_I),
    .lvl_o(rx_det_lvl), .dig_o());
  rsc_lvl4 u_loop (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .th_i(LOOPBACK_SEL_TH_I),
    .lvl_o(loop_lvl), .dig_o());
  rsc_sync2 #(.W(2)) u_pins (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I),
    .d_i({CABLE_ABSENT_I, EE_LOAD_START_N_I}), .q_o({cable_abs_s, start_n_s}));

  // ----------------------------------------------------------------
  // mode select
  // ----------------------------------------------------------------
  rsc_pkg::rsc_mode_e mode, mode_q;
  logic mb_mode;

  // 20k to ground is not a defined mode; it falls back to strap mode
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mode <= rsc_pkg::MODE_STRAP;
    end else begin
      case (mode_lvl)
        rsc_pkg::LVL_VDD1K: mode <= rsc_pkg::MODE_REG_SLAVE;
        rsc_pkg::LVL_FLOAT: mode <= rsc_pkg::MODE_EE_MASTER;
        default: mode <= rsc_pkg::MODE_STRAP;
      endcase
    end
  end
  assign mb_mode = (mode != rsc_pkg::MODE_STRAP);

  // ----------------------------------------------------------------
  // eeprom load sequencer
  // ----------------------------------------------------------------
  rsc_pkg::rsc_load_e ld_state, next_ld;
  logic bus_ok, ee_busy;

  always_comb begin
    next_ld = ld_state;
    case (ld_state)
      rsc_pkg::LD_IDLE: begin
        if (mode == rsc_pkg::MODE_EE_MASTER) begin
          next_ld = rsc_pkg::LD_WAIT;
        end
      end
      rsc_pkg::LD_WAIT: begin
        if (mode != rsc_pkg::MODE_EE_MASTER) begin
          next_ld = rsc_pkg::LD_IDLE;
        end else if (!start_n_s) begin
          next_ld = rsc_pkg::LD_BUSY;
        end
      end
      rsc_pkg::LD_BUSY: begin
        if (EE_ERR_I) begin
          next_ld = rsc_pkg::LD_FAIL;
        end else if (EE_DONE_I) begin
          next_ld = rsc_pkg::LD_PASS;
        end
      end
      // a failed load is only left by reset
      rsc_pkg::LD_FAIL: next_ld = rsc_pkg::LD_FAIL;
      default: next_ld = ld_state;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ld_state <= rsc_pkg::LD_IDLE;
    end else begin
      ld_state <= next_ld;
    end
  end

  // status pin follows the sequencer
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      LOAD_DONE_N_O <= 1'b1;
    end else begin
      LOAD_DONE_N_O <= (ld_state != rsc_pkg::LD_PASS);
    end
  end

  assign ee_busy = (ld_state == rsc_pkg::LD_BUSY);
  assign EE_LOAD_REQ_O = ee_busy;
  // host locked out while loading and for good after a failure
  assign bus_ok = !ee_busy && (ld_state != rsc_pkg::LD_FAIL);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] eq_reg, de_reg, wdata, rd_mux, stat;
  logic [7:0] waddr;
  logic wr_any;
  logic [3:0] irq_st, irq_en, irq_ev;

  // loader writes share the decode; it owns the port while busy
  assign wr_any = ee_busy ? EE_WR_I : (REG_WR_I && bus_ok);
  assign waddr = ee_busy ? EE_ADDR_I : REG_ADDR_I;
  assign wdata = ee_busy ? EE_WDATA_I : REG_WDATA_I;

  // per-channel settings, nibble n for channel n
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      eq_reg <= rsc_pkg::EQ_RST;
      de_reg <= rsc_pkg::DE_RST;
    end else if (wr_any) begin
      if (waddr == rsc_pkg::REG_EQ_OFS) begin
        eq_reg <= wdata;
      end else if (waddr == rsc_pkg::REG_DE_OFS) begin
        de_reg <= wdata;
      end
    end
  end

  // interrupt enable
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      irq_en <= rsc_pkg::IRQ_EN_RST;
    end else if (wr_any && waddr == rsc_pkg::REG_IRQ_EN_OFS) begin
      irq_en <= wdata[3:0];
    end
  end

  // events: mode change, cable change, load passed, load failed
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mode_q <= rsc_pkg::MODE_STRAP;
    end else begin
      mode_q <= mode;
    end
  end
  assign irq_ev[rsc_pkg::IRQ_MODE] = (mode != mode_q);
  assign irq_ev[rsc_pkg::IRQ_CABLE] = (cable_abs_s != LOW_POWER_O);
  assign irq_ev[rsc_pkg::IRQ_PASS] = ee_busy && (next_ld == rsc_pkg::LD_PASS);
  assign irq_ev[rsc_pkg::IRQ_FAIL] = ee_busy && (next_ld == rsc_pkg::LD_FAIL);

  // sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      irq_st <= 4'h0;
    end else if (wr_any && waddr == rsc_pkg::REG_IRQ_CLR_OFS) begin
      irq_st <= (irq_st & ~wdata[3:0]) | irq_ev;
    end else begin
      irq_st <= irq_st | irq_ev;
    end
  end
  assign IRQ_O = |(irq_st & irq_en);

  // status word
  always_comb begin
    stat = 32'h0000_0000;
    stat[rsc_pkg::STAT_MODE_LSB +: 2] = mode;
    stat[rsc_pkg::STAT_RATE_LSB +: 2] = RATE_MODE_O;
    stat[rsc_pkg::STAT_A2B] = LOOP_A2B_O;
    stat[rsc_pkg::STAT_B2A] = LOOP_B2A_O;
    stat[rsc_pkg::STAT_CABLE] = LOW_POWER_O;
    stat[rsc_pkg::STAT_PASS] = (ld_state == rsc_pkg::LD_PASS);
    stat[rsc_pkg::STAT_FAIL] = (ld_state == rsc_pkg::LD_FAIL);
  end

  // read decode; clear register and unmapped addresses read zero
  always_comb begin
    if (REG_ADDR_I == rsc_pkg::REG_EQ_OFS) begin
      rd_mux = eq_reg;
    end else if (REG_ADDR_I == rsc_pkg::REG_DE_OFS) begin
      rd_mux = de_reg;
    end else if (REG_ADDR_I == rsc_pkg::REG_STAT_OFS) begin
      rd_mux = stat;
    end else if (REG_ADDR_I == rsc_pkg::REG_IRQ_ST_OFS) begin
      rd_mux = {28'h0, irq_st};
    end else if (REG_ADDR_I == rsc_pkg::REG_IRQ_EN_OFS) begin
      rd_mux = {28'h0, irq_en};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // read data stand one cycle only, zero otherwise
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      REG_RDATA_O <= 32'h0000_0000;
    end else begin
      REG_RDATA_O <= (REG_RD_I && bus_ok) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // lane settings
  // ----------------------------------------------------------------
  logic [3:0] eq_a, eq_b, de_a, de_b;
  assign eq_a = {eqa1, eqa0};
  assign eq_b = {eqb1, eqb0};
  assign de_a = {dea1, dea0};
  assign de_b = {deb1, deb0};

  // banks of four channels in strap mode, registers otherwise
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      CH_EQ_O <= rsc_pkg::EQ_RST;
      CH_DEEMPH_O <= rsc_pkg::DE_RST;
    end else if (!mb_mode) begin
      CH_EQ_O <= {{4{eq_b}}, {4{eq_a}}};
      CH_DEEMPH_O <= {{4{de_b}}, {4{de_a}}};
    end else begin
      CH_EQ_O <= eq_reg;
      CH_DEEMPH_O <= de_reg;
    end
  end

  // rate applies in every mode
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RATE_MODE_O <= rsc_pkg::RATE_GEN12;
    end else begin
      case (rate_lvl)
        rsc_pkg::LVL_GND1K: RATE_MODE_O <= rsc_pkg::RATE_GEN12;
        rsc_pkg::LVL_FLOAT: RATE_MODE_O <= rsc_pkg::RATE_AUTO;
        rsc_pkg::LVL_GND20K: RATE_MODE_O <= rsc_pkg::RATE_GEN3;
        default: RATE_MODE_O <= rsc_pkg::RATE_RSVD;
      endcase
    end
  end

  // loopback; 20k to ground is undefined and kept as normal routing
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      LOOP_A2B_O <= 1'b0;
      LOOP_B2A_O <= 1'b0;
    end else begin
      LOOP_A2B_O <= (loop_lvl == rsc_pkg::LVL_GND1K);
      LOOP_B2A_O <= (loop_lvl == rsc_pkg::LVL_VDD1K);
    end
  end

  // termination, cable presence
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      TERM_50_O <= 1'b0;
      LOW_POWER_O <= 1'b1;
      CH_EN_O <= 1'b0;
    end else begin
      TERM_50_O <= (rx_det_lvl != rsc_pkg::LVL_GND1K);
      LOW_POWER_O <= cable_abs_s;
      CH_EN_O <= !cable_abs_s;
    end
  end

  // ----------------------------------------------------------------
  // reused pins in bus mode (eeprom master or register slave)
  // ----------------------------------------------------------------
  assign MGMT_SDA_O = 1'b0;
  assign MGMT_SCL_O = 1'b0;

  // pins freed only in bus mode so straps never see a drive
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      MB_EN_O <= 1'b0;
      MB_SDA_O <= 1'b1;
      MB_SCL_O <= 1'b1;
      MGMT_SDA_OE_O <= 1'b0;
      MGMT_SCL_OE_O <= 1'b0;
      SLAVE_ADDR_PINS_O <= 4'h0;
    end else begin
      MB_EN_O <= mb_mode && bus_ok;
      MB_SDA_O <= mb_mode ? dea0_dig : 1'b1;
      MB_SCL_O <= mb_mode ? dea1_dig : 1'b1;
      MGMT_SDA_OE_O <= mb_mode && MB_SDA_DRV_LOW_I;
      MGMT_SCL_OE_O <= mb_mode && MB_SCL_DRV_LOW_I;
      SLAVE_ADDR_PINS_O <= mb_mode ? {eqb0_dig, eqb1_dig, deb0_dig, deb1_dig} : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  load_done_pin_a: assert property (
    (ld_state == rsc_pkg::LD_PASS) |=> !LOAD_DONE_N_O)
    else $error("load done not low after pass");
  strap_eq_a: assert property (
    !mb_mode |=> CH_EQ_O[3:0] == $past(eq_a) && CH_EQ_O[31:28] == $past(eq_b))
    else $error("strap equalization wrong");
  bank_split_a: assert property (
    !mb_mode ##1 !mb_mode |=> CH_EQ_O[15:12] == CH_EQ_O[3:0] && CH_EQ_O[19:16] == CH_EQ_O[31:28])
    else $error("bank grouping wrong");
  reg_settings_a: assert property (
    mb_mode |=> CH_EQ_O == $past(eq_reg) && CH_DEEMPH_O == $past(de_reg))
    else $error("register settings not applied");
  addr_hi_a: assert property (
    mb_mode |=> SLAVE_ADDR_PINS_O[3] == $past(eqb0_dig) && SLAVE_ADDR_PINS_O[2] == $past(eqb1_dig))
    else $error("upper address bits wrong");
  strap_de_a: assert property (
    !mb_mode |=> CH_DEEMPH_O[3:0] == $past(de_a) && CH_DEEMPH_O[31:28] == $past(de_b))
    else $error("strap de-emphasis wrong");
  mgmt_pins_a: assert property (
    mb_mode |=> MB_SCL_O == $past(dea1_dig) && SLAVE_ADDR_PINS_O[0] == $past(deb1_dig))
    else $error("reused pins wrong");
  rate_gen3_a: assert property (
    (rate_lvl == rsc_pkg::LVL_GND20K) |=> RATE_MODE_O == rsc_pkg::RATE_GEN3)
    else $error("rate decode wrong");
  loop_route_a: assert property (
    (loop_lvl == rsc_pkg::LVL_VDD1K) |=> LOOP_B2A_O && !LOOP_A2B_O)
    else $error("loopback decode wrong");
  term_sel_a: assert property (
    (rx_det_lvl == rsc_pkg::LVL_GND1K) |=> !TERM_50_O)
    else $error("termination decode wrong");
  low_power_a: assert property (
    cable_abs_s |=> LOW_POWER_O && !CH_EN_O)
    else $error("low power not entered");
  mode_float_a: assert property (
    (mode_lvl == rsc_pkg::LVL_FLOAT) |=> mode == rsc_pkg::MODE_EE_MASTER)
    else $error("float mode decode wrong");
  load_start_a: assert property (
    (ld_state == rsc_pkg::LD_WAIT && mode == rsc_pkg::MODE_EE_MASTER && !start_n_s)
      |=> ee_busy)
    else $error("load not started");
  fail_stuck_a: assert property (
    (ld_state == rsc_pkg::LD_FAIL) |=> (LOAD_DONE_N_O && REG_RDATA_O == 32'h0 && !MB_EN_O)[*3])
    else $error("failed load not held");

  ee_pass_c: cover property (ee_busy ##1 ld_state == rsc_pkg::LD_PASS);
  ee_fail_c: cover property (ee_busy ##1 ld_state == rsc_pkg::LD_FAIL);
  reg_write_c: cover property (REG_WR_I && bus_ok && mb_mode);
  irq_fire_c: cover property ($rose(IRQ_O));

endmodule

`default_nettype wire

// *** rsc_sync2.sv ***
`timescale 1ns/100ps
`default_nettype none

// two-flop synchroniser for plain two-level pins
module rsc_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // pin side and synchronised side
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // meta is read by q_o only
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

`default_nettype wire
